// [wdc_cnt_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface wdc_cnt_if;
    logic        clear;
    logic        run;
    logic        tick;
    logic [4:0]  period_select;
    logic        timeout;
    logic [23:0] count;

    modport ctrl (output clear, output run, output tick, output period_select,
                  input timeout, input count);
    modport cnt  (input clear, input run, input tick, input period_select,
                  output timeout, output count);
endinterface // wdc_cnt_if
`default_nettype wire

// [wdc_counter.sv]
`timescale 1ns/10ps
`default_nettype none
module wdc_counter (
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    wdc_cnt_if.cnt    bus
);
    logic [23:0] count_ff;
    logic        timeout_ff;
    logic [23:0] limit;

    assign limit = wdc_pkg::prescale_of(bus.period_select); // [RQ3] [RQ4]

    // ------------------------------------------------------------
    // oscillator cycle counter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            count_ff   <= wdc_pkg::CNT_RESET;
            timeout_ff <= 1'b0;
        end else begin
            timeout_ff <= 1'b0;
            if (bus.clear) begin
                count_ff <= wdc_pkg::CNT_RESET; // [RQ17]
            end else if (bus.run && bus.tick) begin
                if (count_ff >= limit - 24'h000001) begin
                    // a shortened period takes effect at once
                    count_ff   <= wdc_pkg::CNT_RESET;
                    timeout_ff <= 1'b1; // [RQ17]
                end else begin
                    count_ff <= count_ff + 24'h000001;
                end
            end
        end
    end

    assign bus.count   = count_ff;
    assign bus.timeout = timeout_ff;
endmodule // wdc_counter
`default_nettype wire

// [wdc_pkg.sv]
// What this block does
// RQ1: five-bit period select chooses nominal time-out from 1 ms to 256 s.
// RQ2: every reset sets period select to 01011 (1:65536) and soft enable to zero.
// RQ3: code 00000 is 1:32; each higher code doubles, up to 10010 at 1:8388608.
// RQ4: reserved codes 10011 to 11111 act as the minimum 1:32 prescale.
// RQ5: count cleared on reset, clear instruction, sleep entry, wake, osc fail, disable, start-up timer.
// RQ6: mode 00, or mode 01 with soft enable zero, holds the watchdog cleared and off.
// RQ7: on sleep exit clear again and hold clear while the start-up timer runs.
// RQ8: clock source switch or divider change leaves the count untouched.
// RQ9: sleep entry clears the count; if enabled in sleep, counting restarts from zero.
// RQ10: time-out during sleep wakes the device instead of resetting it.
// RQ11: time-out updates expired flag and power-down flag in status.
// RQ12: soft enable acts only in mode 01; ignored in modes 1x and 00.
// RQ13: prescaler counts the independent 31 kHz low-frequency oscillator.
// RQ14: control holds bits 7-6 reading zero, period select 5-1, soft enable 0.
// RQ15: awake and enabled, a missed clear within the period resets the device.
// RQ16: mode 11 always active, mode 10 active awake and off in sleep.
// RQ17: counter of oscillator cycles signals time-out at prescale, restarts after clear.
// RQ18: firmware clears well inside the period, allowing for oscillator tolerance.
package wdc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_MASK    = 8'h08;
    localparam logic [7:0] ADDR_COUNT   = 8'h0c;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int         CTL_EN_BIT      = 0;
    localparam int         CTL_PS_LSB      = 1;
    localparam int         PS_W            = 5;
    localparam logic [4:0] PS_RESET        = 5'h0b;
    localparam logic       SOFT_EN_RESET   = 1'b0;
    localparam logic [4:0] PS_MAX_CODE     = 5'h12;
    localparam int         STAT_W          = 2;
    localparam int         STAT_EXPIRED    = 0;
    localparam int         STAT_POWER_DOWN = 1;
    localparam logic [1:0] STAT_RESET      = 2'h0;
    localparam logic [1:0] MASK_RESET      = 2'h0;

    // ------------------------------------------------------------
    // counter sizing
    // ------------------------------------------------------------
    localparam int          CNT_W        = 24;
    localparam logic [23:0] PRESCALE_MIN = 24'h000020;
    localparam logic [23:0] CNT_RESET    = 24'h000000;

    // ------------------------------------------------------------
    // configuration modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WDC_MODE_OFF    = 2'h0,
        WDC_MODE_SOFT   = 2'h1,
        WDC_MODE_NOSLP  = 2'h2,
        WDC_MODE_ALWAYS = 2'h3
    } wdc_mode_t;

    // prescale for a period select code
    function automatic logic [23:0] prescale_of(input logic [4:0] code);
        logic [23:0] val;
        val = PRESCALE_MIN;
        if (code <= PS_MAX_CODE) begin
            val = PRESCALE_MIN << code;
        end
        return val;
    endfunction

endpackage

// [wdc_sync2.sv]
`timescale 1ns/10ps
`default_nettype none
module wdc_sync2 (
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // wdc_sync2
`default_nettype wire

// [wdc_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, wdt_rst, wake, irq;
    logic        osc = 1'b0;
    logic        sleep = 1'b0;
    logic        osc_startup_timer = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic [2:0]  ev = 3'h0;
    int          fails = 0;
    int          checks_done = 0;
    int          n_rst = 0;
    int          n_wake = 0;

    always #50 clk = ~clk;

    wdc_top DUT (.core_clk_in(clk), .reset_in(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_freq_internal_osc_in(osc), .config_mode_bits_in(mode), .sleep_in(sleep),
        .clear_instruction_in(ev[0]), .wake_interrupt_in(ev[1]), .osc_fail_in(ev[2]),
        .osc_startup_timer_in(osc_startup_timer), .wdt_reset_out(wdt_rst), .wake_out(wake), .irq_out(irq));

    always @(posedge clk) begin
        if (wdt_rst === 1'b1) n_rst++;
        if (wake === 1'b1) n_wake++;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic report_and_stop;
        if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            report_and_stop();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk_val(r, x);
        chk_bit(e, xe);
    endtask

    // slow enough that every edge passes the two-flop synchroniser
    task automatic tick(input int n);
        repeat (n) begin
            osc <= 1'b1;
            repeat (4) @(posedge clk);
            osc <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    // whole-vector write: an automatic index on a non-blocking target is refused by some tools
    task automatic kick(input int i);
        ev <= 3'h1 << i;
        @(posedge clk);
        ev <= 3'h0;
        @(posedge clk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic regs;
        rd(8'h00, 32'h16, 1'b0);
        rd(8'h04, 32'h0, 1'b0);
        rd(8'h08, 32'h0, 1'b0);
        wr(8'h00, 32'hffff_ffff);
        rd(8'h00, 32'h3f, 1'b0);
        rd(8'h40, 32'h0, 1'b1);
        wr(8'h0c, 32'h0000_00ff);
        rd(8'h0c, 32'h0, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h00, 32'h16, 1'b0);
    endtask

    task automatic period(input logic [1:0] m, input logic s, input logic sl, input logic [4:0] c,
                          input int e, input int xr, input int xw);
        int r0;
        int w0;
        mode <= m;
        sleep <= sl;
        @(posedge clk);
        wr(8'h00, {26'h0, c, s});
        kick(0);
        r0 = n_rst;
        w0 = n_wake;
        tick(e - 1);
        chk_val(32'(n_rst - r0 + n_wake - w0), 32'h0);
        tick(1);
        repeat (8) @(posedge clk);
        chk_val(32'(n_rst - r0), 32'(xr));
        chk_val(32'(n_wake - w0), 32'(xw));
        if (xr + xw > 0) begin
            rd(8'h04, {30'h0, sl, 1'b1}, 1'b0);
            wr(8'h08, 32'h3);
            chk_bit(irq, 1'b1);
            wr(8'h04, 32'h3);
            chk_bit(irq, 1'b0);
            wr(8'h08, 32'h0);
        end
    endtask

    // each segment alone stays under 32 ticks except the 40 held clear by the start-up timer; without the clears two segments would time out
    task automatic clear_mid;
        int r0;
        int w0;
        period(2'h3, 1'b0, 1'b0, 5'h00, 1, 0, 0);
        r0 = n_rst;
        w0 = n_wake;
        tick(20);
        kick(0);
        tick(20);
        kick(2);
        tick(20);
        kick(1);
        tick(20);
        osc_startup_timer <= 1'b1;
        tick(40);
        osc_startup_timer <= 1'b0;
        tick(20);
        sleep <= 1'b1;
        tick(20);
        sleep <= 1'b0;
        tick(20);
        chk_val(32'(n_rst - r0 + n_wake - w0), 32'h0);
        rd(8'h0c, 32'h14, 1'b0);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        regs();
        period(2'h3, 1'b0, 1'b0, 5'h00, 32, 1, 0);
        period(2'h3, 1'b0, 1'b0, 5'h01, 64, 1, 0);
        period(2'h3, 1'b0, 1'b0, 5'h13, 32, 1, 0);
        period(2'h3, 1'b0, 1'b0, 5'h1f, 32, 1, 0);
        period(2'h3, 1'b0, 1'b1, 5'h00, 32, 0, 1);
        period(2'h2, 1'b0, 1'b0, 5'h00, 32, 1, 0);
        period(2'h2, 1'b0, 1'b1, 5'h00, 32, 0, 0);
        period(2'h1, 1'b1, 1'b0, 5'h00, 32, 1, 0);
        period(2'h1, 1'b1, 1'b1, 5'h00, 32, 0, 1);
        period(2'h1, 1'b0, 1'b0, 5'h00, 32, 0, 0);
        period(2'h0, 1'b1, 1'b0, 5'h00, 32, 0, 0);
        clear_mid();
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire

// [wdc_top.sv]
`timescale 1ns/10ps
`default_nettype none
module wdc_top (
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // device side
    input  wire logic        low_freq_internal_osc_in,
    input  wire logic [1:0]  config_mode_bits_in,
    input  wire logic        sleep_in,
    input  wire logic        clear_instruction_in,
    input  wire logic        wake_interrupt_in,
    input  wire logic        osc_fail_in,
    input  wire logic        osc_startup_timer_in,
    output logic             wdt_reset_out,
    output logic             wake_out,
    output logic             irq_out
);
    wdc_cnt_if cnt_bus ();

    logic [4:0]  period_select_ff;
    logic        soft_enable_ff;
    logic [1:0]  status_ff;
    logic [1:0]  mask_ff;
    logic        sleep_ff;
    logic        osc_prev_ff;
    logic        reset_pulse_ff;
    logic        wake_pulse_ff;
    logic [31:0] prdata_ff;
    logic        osc_sync;
    logic        active;
    logic        sleep_edge;
    logic        access;
    logic        wr_ctl;
    logic        wr_stat;
    logic        wr_mask;
    logic        mapped;
    logic [1:0]  set_stat;
    logic [31:0] nxt_prdata;
    wdc_pkg::wdc_mode_t mode;

    // ------------------------------------------------------------
    // oscillator input and tick
    // ------------------------------------------------------------
    // 31 kHz oscillator sampled at 10 MHz; each rising edge is one tick
    wdc_sync2 u_osc_sync (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .async_in    (low_freq_internal_osc_in),
        .sync_out    (osc_sync)
    );

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            osc_prev_ff <= 1'b0;
        end else begin
            osc_prev_ff <= osc_sync;
        end
    end

    assign cnt_bus.tick = osc_sync && !osc_prev_ff; // [RQ13]

    // ------------------------------------------------------------
    // mode and enable
    // ------------------------------------------------------------
    assign mode = wdc_pkg::wdc_mode_t'(config_mode_bits_in);

    always_comb begin
        active = 1'b0;
        case (mode)
            wdc_pkg::WDC_MODE_ALWAYS: active = 1'b1;          // [RQ16]
            wdc_pkg::WDC_MODE_NOSLP:  active = !sleep_in;     // [RQ16]
            wdc_pkg::WDC_MODE_SOFT:   active = soft_enable_ff; // [RQ12] [RQ6]
            default:                  active = 1'b0;          // [RQ6] [RQ12]
        endcase
    end

    // ------------------------------------------------------------
    // clearing conditions
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sleep_ff <= 1'b0;
        end else begin
            sleep_ff <= sleep_in;
        end
    end

    // either edge: entry clears, exit clears again
    assign sleep_edge = sleep_in ^ sleep_ff; // [RQ9] [RQ7]

    // no clock switch or divider input reaches here, so those leave the count alone [RQ8]
    assign cnt_bus.clear = !active
                        || clear_instruction_in
                        || sleep_edge
                        || wake_interrupt_in
                        || osc_fail_in
                        || osc_startup_timer_in; // [RQ5] [RQ7]
    assign cnt_bus.run           = active; // [RQ9]
    assign cnt_bus.period_select = period_select_ff; // [RQ1]

    wdc_counter u_counter (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .bus         (cnt_bus.cnt)
    );

    // ------------------------------------------------------------
    // time-out actions
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            reset_pulse_ff <= 1'b0;
            wake_pulse_ff  <= 1'b0;
        end else begin
            reset_pulse_ff <= cnt_bus.timeout && !sleep_in; // [RQ15]
            wake_pulse_ff  <= cnt_bus.timeout && sleep_in;  // [RQ10]
        end
    end

    assign wdt_reset_out = reset_pulse_ff;
    assign wake_out      = wake_pulse_ff;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign access  = psel && penable;
    assign pready  = 1'b1;

    always_comb begin
        mapped = 1'b0;
        if (paddr == wdc_pkg::ADDR_CONTROL) begin
            mapped = 1'b1;
        end else if (paddr == wdc_pkg::ADDR_STATUS) begin
            mapped = 1'b1;
        end else if (paddr == wdc_pkg::ADDR_MASK) begin
            mapped = 1'b1;
        end else if (paddr == wdc_pkg::ADDR_COUNT) begin
            mapped = 1'b1;
        end
    end

    assign pslverr = access && !mapped;
    assign wr_ctl  = access && pwrite && (paddr == wdc_pkg::ADDR_CONTROL);
    assign wr_stat = access && pwrite && (paddr == wdc_pkg::ADDR_STATUS);
    assign wr_mask = access && pwrite && (paddr == wdc_pkg::ADDR_MASK);

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // only the system reset restores these; a watchdog reset acts through reset_in
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            period_select_ff <= wdc_pkg::PS_RESET;      // [RQ2]
            soft_enable_ff   <= wdc_pkg::SOFT_EN_RESET; // [RQ2]
        end else if (wr_ctl) begin
            period_select_ff <= pwdata[wdc_pkg::CTL_PS_LSB +: wdc_pkg::PS_W]; // [RQ14]
            soft_enable_ff   <= pwdata[wdc_pkg::CTL_EN_BIT];                  // [RQ14]
        end
    end

    // ------------------------------------------------------------
    // status and mask
    // ------------------------------------------------------------
    always_comb begin
        set_stat = 2'h0;
        set_stat[wdc_pkg::STAT_EXPIRED]    = cnt_bus.timeout;             // [RQ11]
        set_stat[wdc_pkg::STAT_POWER_DOWN] = cnt_bus.timeout && sleep_in; // [RQ11]
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            status_ff <= wdc_pkg::STAT_RESET;
        end else begin
            // a new event wins over a write-one clear in the same cycle
            status_ff <= (status_ff & ~(wr_stat ? pwdata[1:0] : 2'h0)) | set_stat; // [RQ11]
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mask_ff <= wdc_pkg::MASK_RESET;
        end else if (wr_mask) begin
            mask_ff <= pwdata[1:0];
        end
    end

    assign irq_out = |(status_ff & mask_ff);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        nxt_prdata = 32'h0;
        if (paddr == wdc_pkg::ADDR_CONTROL) begin
            nxt_prdata[wdc_pkg::CTL_PS_LSB +: wdc_pkg::PS_W] = period_select_ff; // [RQ14]
            nxt_prdata[wdc_pkg::CTL_EN_BIT]                  = soft_enable_ff;
        end else if (paddr == wdc_pkg::ADDR_STATUS) begin
            nxt_prdata[1:0] = status_ff;
        end else if (paddr == wdc_pkg::ADDR_MASK) begin
            nxt_prdata[1:0] = mask_ff;
        end else if (paddr == wdc_pkg::ADDR_COUNT) begin
            nxt_prdata[23:0] = cnt_bus.count;
        end
    end

    // captured in setup so data stand registered through the access phase
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            prdata_ff <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;
endmodule // wdc_top
`default_nettype wire

// [wdc_top_props.sv]
`timescale 1ns/10ps
`default_nettype none
module wdc_top_props (
    input wire logic       core_clk_in,
    input wire logic       reset_in,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [1:0] config_mode_bits_in,
    input wire logic       sleep_in,
    input wire logic       clear_instruction_in,
    input wire logic       osc_startup_timer_in,
    input wire logic       wdt_reset_out,
    input wire logic       wake_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    logic [7:0] gap_ff;
    // synced ticks are two clocks apart at best, so 32 of them need 62+ cycles
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in)
            gap_ff <= 8'h00;
        else if (clear_instruction_in || wdt_reset_out || wake_out)
            gap_ff <= 8'h00;
        else if (gap_ff != 8'hff)
            gap_ff <= gap_ff + 8'h01;
    end
    chk_awake_rst: assert property (wdt_reset_out |-> !$past(sleep_in))
        else $error("reset pulse while asleep");
    chk_sleep_wake: assert property (wake_out |-> $past(sleep_in))
        else $error("wake pulse while awake");
    chk_one_pulse: assert property (wdt_reset_out || wake_out |=> !wdt_reset_out && !wake_out)
        else $error("time-out pulse too long");
    chk_min_gap: assert property (wdt_reset_out |-> gap_ff >= 8'd60 || $past(clear_instruction_in))
        else $error("time-out sooner than minimum period");
    chk_off_quiet: assert property ((config_mode_bits_in == 2'h0)[*4] |-> !wdt_reset_out && !wake_out)
        else $error("time-out while off");
    chk_sleep_off: assert property ((config_mode_bits_in == 2'h2 && sleep_in)[*4] |-> !wake_out)
        else $error("wake while off in sleep");
    chk_clear_holds: assert property (clear_instruction_in |-> ##2 (!wdt_reset_out && !wake_out)[*8])
        else $error("time-out right after clear");
    chk_ost_holds: assert property (osc_startup_timer_in[*4] |-> !wdt_reset_out && !wake_out)
        else $error("time-out during start-up timer");
    chk_err_map: assert property (psel && penable && paddr > 8'h0c |-> pslverr)
        else $error("no error on unmapped address");
    chk_err_phase: assert property (pslverr |-> psel && penable && pready)
        else $error("error outside access phase");
    cover property (wdt_reset_out);
    cover property (wake_out);
    cover property (pslverr);
endmodule // wdc_top_props
bind wdc_top wdc_top_props u_props (.core_clk_in(core_clk_in), .reset_in(reset_in), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .config_mode_bits_in(config_mode_bits_in),
    .sleep_in(sleep_in), .clear_instruction_in(clear_instruction_in), .osc_startup_timer_in(osc_startup_timer_in),
    .wdt_reset_out(wdt_reset_out), .wake_out(wake_out));
`default_nettype wire
